// ---- src/clc_regs.sv ----
// ahb-lite register bank for the per-cycle current limiter and fault clear
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/10ps
module clc_regs
  import clc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic limit_event_raw,
  output logic limiter_enable,
  output logic [1:0] limit_level_select,
  output logic [6:0] limit_percent,
  output logic limiter_warning,
  output logic limiter_fault,
  output logic analog_fault_clear
);

  logic [7:0] control_ff;
  logic [7:0] nxt_control;
  logic [7:0] rsvd_clear_ff;
  logic clear_pulse_ff;
  clc_aphase_type aphase_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic addr_valid;
  logic wr_control;
  logic wr_clear;
  clc_ctrl_type ctrl;

  // -----------------------------------------------------------------------
  // address phase capture
  // -----------------------------------------------------------------------
  // only nonseq/seq transfers with hready high are real; idle and busy pass
  assign addr_valid = hsel & hready & htrans[1];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aphase_ff <= '0;
    end else if (hready) begin
      aphase_ff.sel <= addr_valid;
      aphase_ff.write <= hwrite;
      aphase_ff.addr <= haddr[CLC_ADDR_W-1:0];
    end
  end

  // the upper address bits are decoded too, so aliases read as zero
  logic upper_zero_ff;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      upper_zero_ff <= 1'b0;
    end else if (hready) begin
      upper_zero_ff <= (haddr[31:CLC_ADDR_W] == '0);
    end
  end

  // -----------------------------------------------------------------------
  // write decode in the data phase
  // -----------------------------------------------------------------------
  assign wr_control = aphase_ff.sel & aphase_ff.write & upper_zero_ff &
                      (aphase_ff.addr == CLC_ADDR_LIMITER_CONTROL);
  assign wr_clear = aphase_ff.sel & aphase_ff.write & upper_zero_ff &
                    (aphase_ff.addr == CLC_ADDR_FAULT_CLEAR);

  // control register keeps all eight bits, reserved ones included
  always_comb begin
    nxt_control = control_ff;
    if (wr_control) begin
      nxt_control = hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_ff <= CLC_CONTROL_RESET;
    end else begin
      control_ff <= nxt_control;
    end
  end

  // reserved low bits of the clear register are plain storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsvd_clear_ff <= CLC_CLEAR_RESET;
    end else if (wr_clear) begin
      rsvd_clear_ff <= {1'b0, hwdata[CLC_CLEAR_BIT-1:0]};
    end
  end

  // clear strobe: high for one cycle after a write with bit 7 set
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clear_pulse_ff <= 1'b0;
    end else begin
      clear_pulse_ff <= wr_clear & hwdata[CLC_CLEAR_BIT];
    end
  end

  // -----------------------------------------------------------------------
  // read path, registered so hrdata comes from flip-flops
  // -----------------------------------------------------------------------
  // read data is fetched in the address phase and shown one cycle later
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (addr_valid & ~hwrite & (haddr[31:CLC_ADDR_W] == '0)) begin
      if (haddr[CLC_ADDR_W-1:0] == CLC_ADDR_LIMITER_CONTROL) begin
        nxt_rdata = {24'h00_0000, nxt_control};
      end else if (haddr[CLC_ADDR_W-1:0] == CLC_ADDR_FAULT_CLEAR) begin
        nxt_rdata = {24'h00_0000, rsvd_clear_ff}; // bit 7 always reads zero
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else if (hready) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // zero wait states, always okay; unmapped words read zero, writes dropped
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // -----------------------------------------------------------------------
  // control fields to the output stage
  // -----------------------------------------------------------------------
  assign limiter_enable = control_ff[CLC_LIMIT_EN_BIT];
  assign limit_level_select = control_ff[CLC_LEVEL_MSB:CLC_LEVEL_LSB];
  assign analog_fault_clear = clear_pulse_ff;

  clc_level_decode u_level (
    .level_code(limit_level_select),
    .limit_percent(limit_percent)
  );

  assign ctrl.limiter_enable = control_ff[CLC_LIMIT_EN_BIT];
  assign ctrl.limiter_warning_enable = control_ff[CLC_WARN_EN_BIT];
  assign ctrl.limiter_fault_enable = control_ff[CLC_FAULT_EN_BIT];
  assign ctrl.limit_percent = limit_percent;

  // -----------------------------------------------------------------------
  // event gating toward warning and fault reporting
  // -----------------------------------------------------------------------
  clc_event_gate u_gate (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .limit_event_raw(limit_event_raw),
    .ctrl(ctrl),
    .limiter_warning(limiter_warning),
    .limiter_fault(limiter_fault)
  );

endmodule

// ---- inc/clc_pkg.sv ----
// package for the current limiter control register bank
package clc_pkg;

  // --------------------------------------------------------------------------
  // register indices and byte addresses
  // --------------------------------------------------------------------------
  // printed offset 77h is not a multiple of four, so both offsets are taken as word indices
  localparam logic [7:0] CLC_IDX_LIMITER_CONTROL = 8'h77;
  localparam logic [7:0] CLC_IDX_FAULT_CLEAR = 8'h78;
  localparam int CLC_ADDR_W = 10;
  localparam logic [CLC_ADDR_W-1:0] CLC_ADDR_LIMITER_CONTROL = {CLC_IDX_LIMITER_CONTROL, 2'b00};
  localparam logic [CLC_ADDR_W-1:0] CLC_ADDR_FAULT_CLEAR = {CLC_IDX_FAULT_CLEAR, 2'b00};

  // --------------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------------
  localparam int CLC_FAULT_EN_BIT = 0;
  localparam int CLC_WARN_EN_BIT = 1;
  localparam int CLC_LIMIT_EN_BIT = 2;
  localparam int CLC_LEVEL_LSB = 3;
  localparam int CLC_LEVEL_MSB = 4;
  localparam int CLC_RSVD_LSB = 5;
  localparam int CLC_RSVD_MSB = 7;
  localparam int CLC_CLEAR_BIT = 7;
  localparam logic [7:0] CLC_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLC_CLEAR_RESET = 8'h00;

  // --------------------------------------------------------------------------
  // limit level codes and their percentage of over-current threshold
  // --------------------------------------------------------------------------
  localparam logic [1:0] CLC_LEVEL_80 = 2'b00;
  localparam logic [1:0] CLC_LEVEL_60 = 2'b10;
  localparam logic [1:0] CLC_LEVEL_40 = 2'b01;
  localparam logic [6:0] CLC_PCT_80 = 7'h50;
  localparam logic [6:0] CLC_PCT_60 = 7'h3C;
  localparam logic [6:0] CLC_PCT_40 = 7'h28;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic limiter_enable;
    logic limiter_warning_enable;
    logic limiter_fault_enable;
    logic [6:0] limit_percent;
  } clc_ctrl_type;

  typedef struct packed {
    logic sel;
    logic write;
    logic [CLC_ADDR_W-1:0] addr;
  } clc_aphase_type;

endpackage

// ---- src/clc_level_decode.sv ----
// decodes the limit level field into a percentage of over-current threshold
`timescale 1ns/10ps
module clc_level_decode
  import clc_pkg::*;
(
  input wire logic [1:0] level_code,
  output logic [6:0] limit_percent
);

  // code 11 is undefined; it falls back to the strongest 80 percent setting
  always_comb begin
    unique case (level_code)
      CLC_LEVEL_60: limit_percent = CLC_PCT_60;
      CLC_LEVEL_40: limit_percent = CLC_PCT_40;
      default: limit_percent = CLC_PCT_80;
    endcase
  end

endmodule

// ---- src/clc_event_gate.sv ----
// gates raw limiter events from the output stage into warning and fault levels
`timescale 1ns/10ps
module clc_event_gate
  import clc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic limit_event_raw,
  input wire clc_pkg::clc_ctrl_type ctrl,
  output logic limiter_warning,
  output logic limiter_fault
);

  logic sync1_ff;
  logic sync2_ff;
  logic warn_ff;
  logic fault_ff;

  // -----------------------------------------------------------------------
  // synchroniser: the analog event is asynchronous to sys_clk
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= limit_event_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // warning follows the event only when limiting and warning are enabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      warn_ff <= 1'b0;
    end else begin
      warn_ff <= sync2_ff & ctrl.limiter_enable & ctrl.limiter_warning_enable;
    end
  end

  // fault follows the event only when limiting and fault are enabled
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= sync2_ff & ctrl.limiter_enable & ctrl.limiter_fault_enable;
    end
  end

  assign limiter_warning = warn_ff;
  assign limiter_fault = fault_ff;

endmodule

// ---- verification/clc_regs_assertions.sv ----
// concurrent checks on the current limiter register bank ports
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------------
module clc_regs_assertions
  import clc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic limit_event_raw,
  input wire logic limiter_enable,
  input wire logic [1:0] limit_level_select,
  input wire logic [6:0] limit_percent,
  input wire logic limiter_warning,
  input wire logic limiter_fault,
  input wire logic analog_fault_clear
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // code 11 is left at the 80 percent level
  property p_pct; limit_percent == (limit_level_select == CLC_LEVEL_60 ? CLC_PCT_60 :
    limit_level_select == CLC_LEVEL_40 ? CLC_PCT_40 : CLC_PCT_80); endproperty
  a_pct: assert property (p_pct) else $error("bad limit percent");
  property p_chg; $changed({limiter_enable, limit_level_select}) |->
    $past(hwrite, 2) && $past(haddr, 2) == 32'(CLC_ADDR_LIMITER_CONTROL); endproperty
  a_chg: assert property (p_chg) else $error("control moved without write");
  property p_off; !$past(limiter_enable) |-> !limiter_warning && !limiter_fault; endproperty
  a_off: assert property (p_off) else $error("report while limiter off");
  // outputs lag the raw event by the two sync stages plus one register
  property p_warn; $rose(limiter_warning) |-> $past(limit_event_raw, 3); endproperty
  a_warn: assert property (p_warn) else $error("warning without event");
  property p_fault; $rose(limiter_fault) |-> $past(limit_event_raw, 3); endproperty
  a_fault: assert property (p_fault) else $error("fault without event");
  property p_clr; analog_fault_clear |-> $past(hwdata[CLC_CLEAR_BIT]) && $past(hwrite, 2) &&
    $past(haddr, 2) == 32'(CLC_ADDR_FAULT_CLEAR); endproperty
  a_clr: assert property (p_clr) else $error("clear without write of one");
  property p_pulse; analog_fault_clear |=> !analog_fault_clear; endproperty
  a_pulse: assert property (p_pulse) else $error("clear held too long");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  c_clr: cover property (analog_fault_clear);
  c_warn: cover property ($rose(limiter_warning));
  c_fault: cover property ($rose(limiter_fault));
endmodule
bind clc_regs clc_regs_assertions u_chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .haddr(haddr),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .limit_event_raw(limit_event_raw),
  .limiter_enable(limiter_enable),
  .limit_level_select(limit_level_select),
  .limit_percent(limit_percent),
  .limiter_warning(limiter_warning),
  .limiter_fault(limiter_fault),
  .analog_fault_clear(analog_fault_clear)
);

// ---- verification/clc_regs_tb.sv ----
// self-checking testbench for the current limiter register bank
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// bench
// ----------------------------------------------------------------------------
module clc_regs_tb;
  import clc_pkg::*;
  localparam logic [31:0] CA = 32'(CLC_ADDR_LIMITER_CONTROL);
  localparam logic [31:0] FA = 32'(CLC_ADDR_FAULT_CLEAR);
  logic sys_clk, rst_b, hsel, hwrite, hready, limit_event_raw, hreadyout, hresp;
  logic limiter_enable, limiter_warning, limiter_fault, analog_fault_clear;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, limit_level_select;
  logic [2:0] hsize;
  logic [6:0] limit_percent;
  int bad_count, tests_run, pulse_cnt;
  // control rows: written value and the percent it should select
  logic [7:0] rw [6] = '{8'h00, 8'h05, 8'h16, 8'h0E, 8'h1B, 8'hE5};
  logic [6:0] rp [6] = '{CLC_PCT_80, CLC_PCT_80, CLC_PCT_60, CLC_PCT_40, CLC_PCT_80, CLC_PCT_80};
  // clear rows: written value, readback, running pulse count
  logic [7:0] cw [3] = '{8'h80, 8'h7F, 8'hFF};
  logic [7:0] cr [3] = '{8'h00, 8'h7F, 8'h7F};
  int cn [3] = '{1, 1, 2};
  assign hready = hreadyout;
  clc_regs u_dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .limit_event_raw(limit_event_raw),
    .limiter_enable(limiter_enable),
    .limit_level_select(limit_level_select),
    .limit_percent(limit_percent),
    .limiter_warning(limiter_warning),
    .limiter_fault(limiter_fault),
    .analog_fault_clear(analog_fault_clear)
  );
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  // counting high cycles catches a clear that lingers
  always @(posedge sys_clk) if (analog_fault_clear === 1'b1) pulse_cnt++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // the run is under a hundred cycles, so this 5000-cycle span is generous
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
  initial begin
    {rst_b, hsel, htrans, hwrite, haddr, hwdata, limit_event_raw} = '0;
    hsize = 3'b010;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    limit_event_raw <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, CA, rw[i]);
      xfer(1'b0, CA, 8'h00);
      chk(r, {24'h0, rw[i]});
      chk(limit_percent, rp[i]);
      chk(limit_level_select, rw[i][4:3]);
      chk(limiter_enable, rw[i][2]);
      chk(limiter_warning, rw[i][2] & rw[i][1]);
      chk(limiter_fault, rw[i][2] & rw[i][0]);
    end
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, FA, cw[i]);
      xfer(1'b0, FA, 8'h00);
      chk(r, {24'h0, cr[i]});
      chk(pulse_cnt, cn[i]);
    end
    // unmapped places read zero and leave control alone
    xfer(1'b1, FA + 32'h4, 8'hFF);
    xfer(1'b0, FA + 32'h4, 8'h00);
    chk(r, 32'h0);
    xfer(1'b1, CA | 32'h400, 8'h00);
    xfer(1'b0, CA, 8'h00);
    chk(r, 32'hE5);
    // fault must follow the event, not just the enables
    limit_event_raw <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(limiter_fault, 1'b0);
    limit_event_raw <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(limiter_fault, 1'b1);
    chk(limiter_warning, 1'b0);
    // second reset in mid-run
    rst_b <= 1'b0;
    @(posedge sys_clk);
    chk({limiter_enable, limit_level_select, limiter_warning, limiter_fault}, 0);
    rst_b <= 1'b1;
    xfer(1'b0, CA, 8'h00);
    chk(r, 32'(CLC_CONTROL_RESET));
    chk(pulse_cnt, 2);
    test_done;
  end
endmodule
